// >>> hdl/cir_codec_interrupt_routing.sv
// Codec interrupt flags, source routing and interrupt output pins
// How it works
// - Flag bit 6 is high while ADC power is below the AGC noise threshold.
// - Flag bit 4 mirrors the engine's standard interrupt port, read-only.
// - Flag bit 3 mirrors the engine's auxiliary interrupt port, read-only.
// - Flag bit 2 shows DC measurement availability, read-only, zero at reset.
// - Select A bit 7 routes headset insertion onto output A.
// - Select A bit 6 routes button press onto output A.
// - Select A bit 5 routes the DRC signal-power event onto output A.
// - Select A bit 4 routes the AGC noise event onto output A.
// - Select A bit 3 routes the short-circuit event onto output A.
// - Select A bit 2 routes engine interrupts onto output A.
// - Select A bit 1 routes DC data available onto output A.
// - Select A bit 0 low gives one 2 ms high pulse per interrupt.
// - Bit 0 high repeats 2 ms pulses every 4 ms until both flags read.
// - Select B routes the same sources, same layout, onto output B.
// - Select B bit 0 picks single or repeating pulses on output B.
`timescale 1ns/1ns
`default_nettype none
module cir_codec_interrupt_routing
    import cir_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic         CLK_SYS,
    input  wire logic         SYS_RST,
    // Register access port
    input  wire logic [7:0]   REG_ADDR,
    input  wire logic         REG_WR,
    input  wire logic         REG_RD,
    input  wire logic [7:0]   REG_WDATA,
    output var  logic [7:0]   REG_RDATA,
    // Event sources, asynchronous levels
    input  wire logic         AGC_NOISE_LOW,
    input  wire logic         ENG_STD_IRQ,
    input  wire logic         ENG_AUX_IRQ,
    input  wire logic         DC_MEAS_AVAIL,
    input  wire logic         HS_INSERT_EVT,
    input  wire logic         BUTTON_EVT,
    input  wire logic         DRC_POWER_EVT,
    input  wire logic         SHORT_EVT,
    // Interrupt pins
    output var  logic         IRQ_OUT_A,
    output var  logic         IRQ_OUT_B
);

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    // Synchronisers
    logic [NUM_EVENTS-1:0]  ev_raw;
    logic [NUM_EVENTS-1:0]  ev_meta_reg;
    logic [NUM_EVENTS-1:0]  ev_sync_reg;

    // Registers
    logic [7:0]             irq_a_sel_reg;
    logic [7:0]             irq_b_sel_reg;
    logic [7:0]             rsvd_reg;
    logic [7:0]             rdata_reg;
    logic [7:0]             rdata_next;

    // Routing
    logic [7:0]             src_vec;
    logic [7:0]             adc_event_flags;
    logic [7:0]             sel [NUM_IRQ];
    logic [NUM_IRQ-1:0]     irq_level;
    logic [NUM_IRQ-1:0]     irq_level_d_reg;
    logic [NUM_IRQ-1:0]     irq_trigger;
    logic [NUM_IRQ-1:0]     pulse_out;
    logic [NUM_IRQ-1:0]     irq_out_reg;

    // Tick divider
    logic [DIV_W-1:0]       div_reg;
    logic                   tick_reg;

    assign ev_raw[EV_AGC_LOW]   = AGC_NOISE_LOW;
    assign ev_raw[EV_ENG_STD]   = ENG_STD_IRQ;
    assign ev_raw[EV_ENG_AUX]   = ENG_AUX_IRQ;
    assign ev_raw[EV_DC_AVAIL]  = DC_MEAS_AVAIL;
    assign ev_raw[EV_HS_INSERT] = HS_INSERT_EVT;
    assign ev_raw[EV_BUTTON]    = BUTTON_EVT;
    assign ev_raw[EV_DRC]       = DRC_POWER_EVT;
    assign ev_raw[EV_SHORT]     = SHORT_EVT;

    // Two flops per event; only the second is read downstream
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST) begin
                    ev_meta_reg[gi] <= 1'b0;
                    ev_sync_reg[gi] <= 1'b0;
                end else begin
                    ev_meta_reg[gi] <= ev_raw[gi];
                    ev_sync_reg[gi] <= ev_meta_reg[gi];
                end
            end
        end
    endgenerate

    // Address decode
    wire logic hit_event_flags = (REG_ADDR == ADDR_ADC_EVENT_FLAGS);
    wire logic hit_irq_a       = (REG_ADDR == ADDR_IRQ_A_SEL);
    wire logic hit_irq_b       = (REG_ADDR == ADDR_IRQ_B_SEL);
    wire logic hit_rsvd        = (REG_ADDR == ADDR_RSVD_AFTER_IRQ);
    wire logic hit_dac_flags   = (REG_ADDR == ADDR_DAC_FLAGS);
    wire logic hit_adc_flags   = (REG_ADDR == ADDR_ADC_FLAGS);

    wire logic wr_irq_a        = REG_WR && hit_irq_a;
    wire logic wr_irq_b        = REG_WR && hit_irq_b;
    wire logic wr_rsvd         = REG_WR && hit_rsvd;
    // Those flag registers live elsewhere; only their reads matter here
    wire logic rd_dac_flags    = REG_RD && hit_dac_flags;
    wire logic rd_adc_flags    = REG_RD && hit_adc_flags;

    // ADC event flag register, read-only view of live state
    always_comb begin
        adc_event_flags               = 8'h00;
        adc_event_flags[FLG_AGC_LOW]  = ev_sync_reg[EV_AGC_LOW];
        adc_event_flags[FLG_ENG_STD]  = ev_sync_reg[EV_ENG_STD];
        adc_event_flags[FLG_ENG_AUX]  = ev_sync_reg[EV_ENG_AUX];
        adc_event_flags[FLG_DC_AVAIL] = ev_sync_reg[EV_DC_AVAIL];
    end

    // Read data select; an unmapped read answers zero
    always_comb begin
        rdata_next = rdata_reg;
        if (REG_RD) begin
            if (hit_event_flags) begin
                rdata_next = adc_event_flags;
            end else if (hit_irq_a) begin
                rdata_next = irq_a_sel_reg;
            end else if (hit_irq_b) begin
                rdata_next = irq_b_sel_reg;
            end else if (hit_rsvd) begin
                rdata_next = rsvd_reg;
            end else begin
                rdata_next = UNMAPPED_RDATA;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rdata_reg <= RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            irq_a_sel_reg <= IRQ_SEL_RESET;
        end else if (wr_irq_a) begin
            irq_a_sel_reg <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            irq_b_sel_reg <= IRQ_SEL_RESET;
        end else if (wr_irq_b) begin
            irq_b_sel_reg <= REG_WDATA;
        end
    end

    // Plain storage; nothing is steered by it
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rsvd_reg <= RSVD_RESET;
        end else if (wr_rsvd) begin
            rsvd_reg <= REG_WDATA;
        end
    end

    // Source vector in select-register bit order
    always_comb begin
        src_vec                = 8'h00;
        src_vec[SEL_HS_INSERT] = ev_sync_reg[EV_HS_INSERT];
        src_vec[SEL_BUTTON]    = ev_sync_reg[EV_BUTTON];
        src_vec[SEL_DRC]       = ev_sync_reg[EV_DRC];
        src_vec[SEL_AGC]       = ev_sync_reg[EV_AGC_LOW];
        src_vec[SEL_SHORT]     = ev_sync_reg[EV_SHORT];
        src_vec[SEL_ENGINE]    = ev_sync_reg[EV_ENG_STD]
                               | ev_sync_reg[EV_ENG_AUX];
        src_vec[SEL_DC]        = ev_sync_reg[EV_DC_AVAIL];
    end

    assign sel[0] = irq_a_sel_reg;
    assign sel[1] = irq_b_sel_reg;

    // Fixed reference tick shared by both outputs; a pulse may start
    // mid-tick, so its width is short by under one tick
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || (div_reg == DIV_LAST)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == DIV_LAST);
        end
    end

    // One routing slice and pulse generator per interrupt output
    cir_pulse_if pif [NUM_IRQ] ();

    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
            // Bit 0 is the mode bit, so the source mask skips it
            assign irq_level[gi] =
                |(src_vec[7:1] & sel[gi][7:1]);
            assign irq_trigger[gi] =
                irq_level[gi] && !irq_level_d_reg[gi];

            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST) begin
                    irq_level_d_reg[gi] <= 1'b0;
                end else begin
                    irq_level_d_reg[gi] <= irq_level[gi];
                end
            end

            assign pif[gi].trigger      = irq_trigger[gi];
            assign pif[gi].repeat_mode  = sel[gi][SEL_REPEAT];
            assign pif[gi].tick         = tick_reg;
            assign pif[gi].rd_dac_flags = rd_dac_flags;
            assign pif[gi].rd_adc_flags = rd_adc_flags;
            assign pulse_out[gi]        = pif[gi].pulse;

            cir_pulse_gen #(
                .WIDTH_TICKS    (PULSE_TICKS),
                .PERIOD_TICKS_P (PERIOD_TICKS)
            ) u_pulse (
                .CLK_SYS (CLK_SYS),
                .SYS_RST (SYS_RST),
                .bus     (pif[gi])
            );

            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST) begin
                    irq_out_reg[gi] <= 1'b0;
                end else begin
                    irq_out_reg[gi] <= pulse_out[gi];
                end
            end
        end
    endgenerate

    assign REG_RDATA = rdata_reg;
    assign IRQ_OUT_A = irq_out_reg[0];
    assign IRQ_OUT_B = irq_out_reg[1];

endmodule // cir_codec_interrupt_routing
`default_nettype wire

// >>> hdl/cir_pkg.sv
// Constants, register map and types for the codec interrupt routing block
package cir_pkg;

    // Register offsets on the control port
    localparam logic [7:0] ADDR_DAC_FLAGS       = 8'h2c;
    localparam logic [7:0] ADDR_ADC_FLAGS       = 8'h2d;
    localparam logic [7:0] ADDR_ADC_EVENT_FLAGS = 8'h2f;
    localparam logic [7:0] ADDR_IRQ_A_SEL       = 8'h30;
    localparam logic [7:0] ADDR_IRQ_B_SEL       = 8'h31;
    localparam logic [7:0] ADDR_RSVD_AFTER_IRQ  = 8'h32;

    // Reset values
    localparam logic [7:0] IRQ_SEL_RESET        = 8'h00;
    localparam logic [7:0] RSVD_RESET           = 8'h00;
    localparam logic [7:0] RDATA_RESET          = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA       = 8'h00;

    // Source select fields, same layout in both select registers
    localparam int SEL_HS_INSERT = 7;
    localparam int SEL_BUTTON    = 6;
    localparam int SEL_DRC       = 5;
    localparam int SEL_AGC       = 4;
    localparam int SEL_SHORT     = 3;
    localparam int SEL_ENGINE    = 2;
    localparam int SEL_DC        = 1;
    localparam int SEL_REPEAT    = 0;

    // ADC event flag fields
    localparam int FLG_AGC_LOW   = 6;
    localparam int FLG_ENG_STD   = 4;
    localparam int FLG_ENG_AUX   = 3;
    localparam int FLG_DC_AVAIL  = 2;

    // Raw event input order
    localparam int EV_AGC_LOW   = 0;
    localparam int EV_ENG_STD   = 1;
    localparam int EV_ENG_AUX   = 2;
    localparam int EV_DC_AVAIL  = 3;
    localparam int EV_HS_INSERT = 4;
    localparam int EV_BUTTON    = 5;
    localparam int EV_DRC       = 6;
    localparam int EV_SHORT     = 7;
    localparam int NUM_EVENTS   = 8;
    localparam int NUM_IRQ      = 2;

    // Timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int TICK_TIME_NS    = 100_000;
    localparam int PULSE_WIDTH_NS  = 2_000_000;
    localparam int PULSE_PERIOD_NS = 4_000_000;
    localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int PULSE_TICKS     = PULSE_WIDTH_NS / TICK_TIME_NS;
    localparam int PERIOD_TICKS    = PULSE_PERIOD_NS / TICK_TIME_NS;
    localparam int DIV_W           = 12;
    localparam int CNT_W           = 6;

    typedef enum logic [1:0] {
        PG_IDLE,
        PG_HIGH,
        PG_LOW
    } cir_pg_state_t;

endpackage : cir_pkg

// >>> hdl/cir_pulse_if.sv
// Interface between the routing top and one pulse generator
`timescale 1ns/1ns
`default_nettype none
interface cir_pulse_if;
    logic trigger;
    logic repeat_mode;
    logic tick;
    logic rd_dac_flags;
    logic rd_adc_flags;
    logic pulse;

    modport gen (
        input  trigger,
        input  repeat_mode,
        input  tick,
        input  rd_dac_flags,
        input  rd_adc_flags,
        output pulse
    );

    modport ctl (
        output trigger,
        output repeat_mode,
        output tick,
        output rd_dac_flags,
        output rd_adc_flags,
        input  pulse
    );
endinterface : cir_pulse_if
`default_nettype wire

// >>> hdl/cir_pulse_gen.sv
// Single or repeating pulse generator for one interrupt output
`timescale 1ns/1ns
`default_nettype none
module cir_pulse_gen
    import cir_pkg::*;
#(
    parameter int WIDTH_TICKS  = PULSE_TICKS,
    parameter int PERIOD_TICKS_P = PERIOD_TICKS
) (
    // Clock and reset
    input  wire logic   CLK_SYS,
    input  wire logic   SYS_RST,
    // Control side
    cir_pulse_if.gen    bus
);

    localparam logic [CNT_W-1:0] WIDTH_LAST  = CNT_W'(WIDTH_TICKS - 1);
    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_TICKS_P - 1);

    cir_pg_state_t      state_reg;
    cir_pg_state_t      state_next;
    logic [CNT_W-1:0]   cnt_reg;
    logic [CNT_W-1:0]   cnt_next;
    logic               pulse_reg;
    logic               pulse_next;
    logic               seen_dac_reg;
    logic               seen_adc_reg;

    wire logic start      = (state_reg == PG_IDLE) && bus.trigger;
    // Reads in this cycle count, so the stop is not a cycle late
    wire logic seen_dac   = seen_dac_reg | bus.rd_dac_flags;
    wire logic seen_adc   = seen_adc_reg | bus.rd_adc_flags;
    wire logic stop       = bus.repeat_mode && seen_dac && seen_adc;
    wire logic width_end  = bus.tick && (cnt_reg == WIDTH_LAST);
    wire logic period_end = bus.tick && (cnt_reg == PERIOD_LAST);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        pulse_next = pulse_reg;
        unique case (state_reg)
            PG_IDLE: begin
                if (bus.trigger) begin
                    state_next = PG_HIGH;
                    cnt_next   = '0;
                    pulse_next = 1'b1;
                end
            end
            PG_HIGH: begin
                if (stop) begin
                    state_next = PG_IDLE;
                    pulse_next = 1'b0;
                end else if (width_end) begin
                    pulse_next = 1'b0;
                    if (bus.repeat_mode) begin
                        state_next = PG_LOW;
                        cnt_next   = cnt_reg + CNT_W'(1);
                    end else begin
                        state_next = PG_IDLE;
                    end
                end else if (bus.tick) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
            PG_LOW: begin
                if (stop || !bus.repeat_mode) begin
                    state_next = PG_IDLE;
                end else if (period_end) begin
                    state_next = PG_HIGH;
                    cnt_next   = '0;
                    pulse_next = 1'b1;
                end else if (bus.tick) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_reg <= PG_IDLE;
            cnt_reg   <= '0;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pulse_reg <= pulse_next;
        end
    end

    // Reads seen before a sequence starts do not count; a read in the
    // start cycle itself wins over the clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            seen_dac_reg <= 1'b0;
            seen_adc_reg <= 1'b0;
        end else if (start) begin
            seen_dac_reg <= bus.rd_dac_flags;
            seen_adc_reg <= bus.rd_adc_flags;
        end else if (stop) begin
            seen_dac_reg <= 1'b0;
            seen_adc_reg <= 1'b0;
        end else begin
            seen_dac_reg <= seen_dac;
            seen_adc_reg <= seen_adc;
        end
    end

    assign bus.pulse = pulse_reg;

endmodule // cir_pulse_gen
`default_nettype wire

// >>> verification/cir_codec_interrupt_routing_asserts.sv
// Port-level assertions for the interrupt routing block
`timescale 1ns/1ns
`default_nettype none
module cir_codec_interrupt_routing_asserts
    import cir_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic       CLK_SYS,
    input wire logic       SYS_RST,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    // Event sources
    input wire logic       AGC_NOISE_LOW,
    input wire logic       ENG_STD_IRQ,
    input wire logic       ENG_AUX_IRQ,
    input wire logic       DC_MEAS_AVAIL,
    input wire logic       HS_INSERT_EVT,
    input wire logic       BUTTON_EVT,
    input wire logic       DRC_POWER_EVT,
    input wire logic       SHORT_EVT,
    // Interrupt pins
    input wire logic       IRQ_OUT_A,
    input wire logic       IRQ_OUT_B
);
    localparam int PW_MIN = (PULSE_TICKS - 1) * TICK_CYCLES + 1;
    localparam int PW_MAX = PULSE_TICKS * TICK_CYCLES + 1;
    // Longer than any low phase of a running repeat, so A is idle
    localparam int LO_MIN = (PERIOD_TICKS - PULSE_TICKS) * TICK_CYCLES + 2;
    logic [7:0] sh_a_reg, sh_b_reg;
    logic [3:0] f1_reg, f2_reg, f3_reg;
    int         hi_a_reg, hi_b_reg, lo_a_reg;
    wire logic [3:0] flags = {AGC_NOISE_LOW, ENG_STD_IRQ, ENG_AUX_IRQ,
        DC_MEAS_AVAIL};
    wire logic [7:0] srcs = {HS_INSERT_EVT, BUTTON_EVT, DRC_POWER_EVT,
        AGC_NOISE_LOW, SHORT_EVT, ENG_STD_IRQ | ENG_AUX_IRQ, DC_MEAS_AVAIL,
        1'b0};
    wire logic en_a = |(srcs & sh_a_reg);
    wire logic rd_flg = REG_RD && REG_ADDR == ADDR_ADC_EVENT_FLAGS;
    wire logic f_stable = flags == f1_reg && f1_reg == f2_reg
        && f2_reg == f3_reg;

    always_ff @(posedge CLK_SYS) begin
        f1_reg <= flags;
        f2_reg <= f1_reg;
        f3_reg <= f2_reg;
        if (SYS_RST) begin
            sh_a_reg <= 8'h00;
            sh_b_reg <= 8'h00;
            hi_a_reg <= 0;
            hi_b_reg <= 0;
            lo_a_reg <= 0;
        end else begin
            if (REG_WR && REG_ADDR == ADDR_IRQ_A_SEL) sh_a_reg <= REG_WDATA;
            if (REG_WR && REG_ADDR == ADDR_IRQ_B_SEL) sh_b_reg <= REG_WDATA;
            hi_a_reg <= IRQ_OUT_A ? hi_a_reg + 1 : 0;
            hi_b_reg <= IRQ_OUT_B ? hi_b_reg + 1 : 0;
            lo_a_reg <= IRQ_OUT_A ? 0 : lo_a_reg + int'(lo_a_reg < LO_MIN);
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    sel_a_read_a: assert property (
        REG_RD && REG_ADDR == ADDR_IRQ_A_SEL |=> REG_RDATA == $past(sh_a_reg))
        else $error("select A readback wrong");
    sel_b_read_a: assert property (
        REG_RD && REG_ADDR == ADDR_IRQ_B_SEL |=> REG_RDATA == $past(sh_b_reg))
        else $error("select B readback wrong");
    flag_read_a: assert property (
        rd_flg && f_stable |=> {REG_RDATA[6], REG_RDATA[4:2]} == $past(flags))
        else $error("event flag bits wrong");
    flag_zero_a: assert property (
        rd_flg |=> !REG_RDATA[7] && !REG_RDATA[5] && REG_RDATA[1:0] == 2'b00)
        else $error("reserved flag bits not zero");
    width_a_a: assert property (
        $fell(IRQ_OUT_A) && !sh_a_reg[0] |-> hi_a_reg inside {[PW_MIN:PW_MAX]})
        else $error("single pulse width on A wrong");
    width_b_a: assert property (hi_b_reg <= PW_MAX)
        else $error("pulse on B too long");
    irq_latency_a: assert property (
        $rose(en_a) && lo_a_reg == LO_MIN |-> ##[1:6] IRQ_OUT_A)
        else $error("enabled event did not raise A");
    irq_cause_a: assert property ($rose(IRQ_OUT_A) |-> sh_a_reg != 8'h00)
        else $error("A rose with no source selected");
endmodule // cir_codec_interrupt_routing_asserts

bind cir_codec_interrupt_routing cir_codec_interrupt_routing_asserts
    #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .AGC_NOISE_LOW(AGC_NOISE_LOW),
    .ENG_STD_IRQ(ENG_STD_IRQ), .ENG_AUX_IRQ(ENG_AUX_IRQ),
    .DC_MEAS_AVAIL(DC_MEAS_AVAIL), .HS_INSERT_EVT(HS_INSERT_EVT),
    .BUTTON_EVT(BUTTON_EVT), .DRC_POWER_EVT(DRC_POWER_EVT),
    .SHORT_EVT(SHORT_EVT), .IRQ_OUT_A(IRQ_OUT_A), .IRQ_OUT_B(IRQ_OUT_B));
`default_nettype wire

// >>> verification/cir_host_model.sv
// Host side of one interrupt pin: counts and times the pulses
`timescale 1ns/1ns
`default_nettype none
module cir_host_model (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Pin and measurements
    input  wire logic irq,
    output var  int   rises,
    output var  int   width,
    output var  int   period
);
    logic irq_reg;
    int   hi_reg, since_reg;
    wire logic rise = irq && !irq_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
            hi_reg <= 0;
            since_reg <= 0;
            rises <= 0;
            width <= 0;
            period <= 0;
        end else begin
            irq_reg <= irq;
            hi_reg <= irq ? hi_reg + 1 : 0;
            since_reg <= rise ? 1 : since_reg + 1;
            if (rise) rises <= rises + 1;
            if (rise) period <= since_reg;
            if (!irq && irq_reg) width <= hi_reg;
        end
    end
endmodule // cir_host_model
`default_nettype wire

// >>> verification/cir_codec_interrupt_routing_tb.sv
// Self-checking bench for the interrupt routing block
`timescale 1ns/1ns
`default_nettype none
module cir_codec_interrupt_routing_tb
    import cir_pkg::*;
    ;
    // Short tick keeps the 2 ms and 4 ms figures to 100 and 200 cycles
    localparam int TICK   = 5;
    localparam int PW_MIN = (PULSE_TICKS - 1) * TICK + 1;
    localparam int PW_MAX = PULSE_TICKS * TICK + 1;
    logic        clk_sys, sys_rst, reg_wr, reg_rd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, ev, m [0:255];
    logic        irq [2];
    int          rises [2], widths [2], periods [2];
    int          errors = 0, comparisons = 0;
    logic [31:0] seed = 32'h8a7ca391;
    int          ev_of [8] = '{0, EV_DC_AVAIL, EV_ENG_STD, EV_SHORT,
        EV_AGC_LOW, EV_DRC, EV_BUTTON, EV_HS_INSERT};

    cir_codec_interrupt_routing #(.TICK_CYCLES(TICK)) u_dut (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .AGC_NOISE_LOW(ev[EV_AGC_LOW]),
        .ENG_STD_IRQ(ev[EV_ENG_STD]), .ENG_AUX_IRQ(ev[EV_ENG_AUX]),
        .DC_MEAS_AVAIL(ev[EV_DC_AVAIL]), .HS_INSERT_EVT(ev[EV_HS_INSERT]),
        .BUTTON_EVT(ev[EV_BUTTON]), .DRC_POWER_EVT(ev[EV_DRC]),
        .SHORT_EVT(ev[EV_SHORT]), .IRQ_OUT_A(irq[0]), .IRQ_OUT_B(irq[1]));
    for (genvar g = 0; g < NUM_IRQ; g++) begin : g_host
        cir_host_model u_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
            .irq(irq[g]), .rises(rises[g]), .width(widths[g]),
            .period(periods[g]));
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        if (a >= ADDR_IRQ_A_SEL && a <= ADDR_RSVD_AFTER_IRQ) m[a] = d;
    endtask
    // Model value is compared one cycle after the read strobe
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk(reg_rdata, m[a]);
    endtask
    task automatic fire(input int k);
        int i;
        i = ev_of[k] + ((k == 2) ? int'(xs() & 1) : 0);
        @(negedge clk_sys);
        ev[i] = 1'b1;
        @(negedge clk_sys);
        ev[i] = 1'b0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
    initial begin
        int b [2];
        logic [31:0] r;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ev = 8'h00;
        foreach (m[i]) m[i] = 8'h00;
        idle(16);
        sys_rst = 1'b0;
        rd(ADDR_IRQ_A_SEL);
        rd(ADDR_IRQ_B_SEL);
        rd(ADDR_RSVD_AFTER_IRQ);
        rd(8'h40);
        for (int n = 0; n < 8; n++) begin
            r = xs();
            wr(ADDR_IRQ_A_SEL, r[7:0]);
            wr(ADDR_IRQ_B_SEL, r[15:8]);
            wr(ADDR_RSVD_AFTER_IRQ, 8'h00);
            wr(ADDR_ADC_EVENT_FLAGS, r[23:16]);
            rd(ADDR_IRQ_A_SEL);
            rd(ADDR_IRQ_B_SEL);
            rd(ADDR_ADC_EVENT_FLAGS);
            rd(ADDR_RSVD_AFTER_IRQ);
        end
        wr(ADDR_IRQ_A_SEL, 8'h00);
        wr(ADDR_IRQ_B_SEL, 8'h00);
        $display("test registers done");
        for (int n = 0; n < 8; n++) begin
            r = xs();
            @(negedge clk_sys);
            ev[3:0] = r[3:0];
            idle(4);
            m[ADDR_ADC_EVENT_FLAGS] = {1'b0, r[EV_AGC_LOW], 1'b0,
                r[EV_ENG_STD], r[EV_ENG_AUX], r[EV_DC_AVAIL], 2'b00};
            rd(ADDR_ADC_EVENT_FLAGS);
        end
        ev = 8'h00;
        m[ADDR_ADC_EVENT_FLAGS] = 8'h00;
        idle(8);
        $display("test flags done");
        for (int k = 1; k < 8; k++) begin
            for (int o = 0; o < 2; o++) begin
                wr(o ? ADDR_IRQ_B_SEL : ADDR_IRQ_A_SEL, 8'h01 << k);
                wr(o ? ADDR_IRQ_A_SEL : ADDR_IRQ_B_SEL, 8'hfe ^ (8'h01 << k));
                b = rises;
                fire(k);
                idle(500);
                chk(8'(rises[o] - b[o]), 8'h01);
                chk(8'(rises[1 - o] - b[1 - o]), 8'h00);
                chk(8'(widths[o] inside {[PW_MIN:PW_MAX]}), 8'h01);
            end
        end
        $display("test routing done");
        for (int o = 0; o < 2; o++) begin
            wr(ADDR_IRQ_A_SEL, o ? 8'h00 : 8'h03);
            wr(ADDR_IRQ_B_SEL, o ? 8'h03 : 8'h00);
            b = rises;
            fire(1);
            idle(650);
            chk(8'(rises[o] - b[o]), 8'h04);
            chk(8'(periods[o]), 8'(PERIOD_TICKS * TICK));
            chk(8'(widths[o] inside {[PW_MIN:PW_MAX]}), 8'h01);
            rd(o ? ADDR_DAC_FLAGS : ADDR_ADC_FLAGS);
            b = rises;
            idle(250);
            chk(8'(rises[o] > b[o]), 8'h01);
            rd(o ? ADDR_ADC_FLAGS : ADDR_DAC_FLAGS);
            idle(2);
            chk({7'h00, irq[o]}, 8'h00);
            b = rises;
            idle(450);
            chk(8'(rises[o] - b[o]), 8'h00);
        end
        $display("test repeat done");
        give_verdict();
    end
endmodule // cir_codec_interrupt_routing_tb
`default_nettype wire
